// ==== logic/mpc_cfg.svh ====
/*
 * Offsets, reset values and timing figures of the multipurpose pin configuration block.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef MPC_CFG_SVH
`define MPC_CFG_SVH

// register indices; byte address is four times the index
`define MPC_IDX_PIN3    10'h033
`define MPC_IDX_PIN4    10'h034
`define MPC_IDX_PIN5    10'h035
`define MPC_IDX_PIN6    10'h036
`define MPC_IDX_GP_OUT  10'h040
`define MPC_IDX_GP_IN   10'h041

// nominal per-pin configuration byte and selector field
`define MPC_CFG_RESET   8'h0A
`define MPC_SEL_MSB     7
`define MPC_SEL_LSB     5

// input deglitch time and clock period
`define MPC_DEGLITCH_NS 8000
`define MPC_CLK_PERIOD_NS 8

`endif

// ==== logic/mpc_pkg.sv ====
/*
 * Types of the multipurpose pin configuration block: function codes and state records.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mpc_pkg;

    // pin function selector codes 0..7 in order
    typedef enum logic [2:0] {
        MPC_FN_GP, MPC_FN_ALT1, MPC_FN_ALT2, MPC_FN_ALT3,
        MPC_FN_SLEEP1, MPC_FN_SLEEP2, MPC_FN_WAKE1, MPC_FN_WAKE2
    } mpc_func_t;

    // state of one deglitch filter
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       level;
        logic [9:0] cnt;
    } mpc_dg_state_t;

    // state of the configuration block
    typedef struct packed {
        logic            loaded;
        logic [3:0][7:0] cfg;
        logic [3:0]      gp_out;
        logic            pready;
        logic [31:0]     prdata;
        logic            pslverr;
        logic [3:0]      pin_out;
        logic [3:0]      pin_oe;
        logic [3:0]      pull_en;
        logic [3:0]      pull_up;
        logic            i2c_in;
        logic            en_in;
        logic            wdog;
        logic            vmon_sel;
        logic            sync_in;
        logic            err_n;
        logic            slp1;
        logic            slp2;
        logic            wk1;
        logic            wk2;
    } mpc_state_t;

endpackage : mpc_pkg

// ==== logic/mpc_deglitch.sv ====
/*
 * Two-flop synchroniser with an optional stability filter for one pin input.
 * Assumes pin_async is asynchronous to pclk and filter_on comes from pclk logic.
 */
`timescale 1ns/1ns
module mpc_deglitch #(
    parameter int CNT_W = 10,
    parameter int COUNT = 1000
) (
    input  wire logic pclk,      // block clock
    input  wire logic presetn,   // async reset, active low
    input  wire logic pin_async, // raw pin level
    input  wire logic filter_on, // apply the stability filter
    output logic      level      // clean level
);
    mpc_pkg::mpc_dg_state_t st_reg;
    mpc_pkg::mpc_dg_state_t st_next;

    // sync1 feeds only sync2; the filter sees the second stage alone
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pin_async;
        st_next.sync2 = st_reg.sync1;
        if (!filter_on) begin
            st_next.level = st_reg.sync2;
            st_next.cnt   = '0;
        end else if (st_reg.sync2 == st_reg.level) begin
            st_next.cnt = '0;  // any bounce restarts the wait
        end else if (st_reg.cnt == CNT_W'(COUNT - 1)) begin
            st_next.level = st_reg.sync2;
            st_next.cnt   = '0;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.level;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_filter_holds: assert property (filter_on && (st_reg.sync2 != st_reg.level)
        && (st_reg.cnt < CNT_W'(COUNT - 1)) |=> (st_reg.level == $past(st_reg.level)))
        else $error("filtered level changed before the deglitch time");
    chk_sync_only: assert property (!filter_on |=> (st_reg.level == $past(st_reg.sync2)))
        else $error("unfiltered level does not follow the synchroniser");

endmodule : mpc_deglitch

// ==== logic/mpc_pin_config.sv ====
/*
 * Configuration and multiplexing of four multipurpose pins (pins 3 to 6) behind an APB slave.
 * Assumes one 125 MHz clock, pin pads resolved outside, and core signals on the same clock.
 */
// Decided for this implementation: the APB register port.
// Notes on behaviour
// - pin3 selector: 0 general purpose, 1 second i2c data, 2 and 3 spi data out.
// - pin4 selector: 0 general purpose, 1 enable, 2 watchdog trigger, 3 monitor input.
// - pin4 code 3 makes the first regulator monitor sample pin4, not its feedback pin.
// - pin5 selector: 0 general purpose, 1 sync clock in, 2 sync out, 3 reset out.
// - pin6 selector: 0 general purpose, 1 error input, 2 sync clock out, 3 power good.
// - codes 4 to 7 on any pin give sleep 1, sleep 2, wake 1, wake 2.
// - bit 4 adds an 8 us deglitch to the synchronised input, only while input.
// - bit 3 enables the pull resistor.
// - bit 2 picks pull-up when set, pull-down when clear; needs bit 3.
// - bit 1 selects open-drain when set, push-pull when clear, for outputs.
// - bit 0 selects output when set, input when clear.
// - reset values come from non-volatile defaults; every field reads and writes.
// - nominal default byte is 0x0A for every pin register.
`timescale 1ns/1ns
`include "mpc_cfg.svh"
module mpc_pin_config #(
    parameter int DG_COUNT = (`MPC_DEGLITCH_NS + `MPC_CLK_PERIOD_NS - 1) / `MPC_CLK_PERIOD_NS
) (
    input  wire logic        pclk,                          // block clock
    input  wire logic        presetn,                       // async reset, active low
    input  wire logic [11:0] paddr,                         // apb byte address
    input  wire logic        psel,                          // apb select
    input  wire logic        penable,                       // apb access phase
    input  wire logic        pwrite,                        // apb direction
    input  wire logic [31:0] pwdata,                        // apb write data
    output logic      [31:0] prdata,                        // apb read data
    output logic             pready,                        // apb ready
    output logic             pslverr,                       // apb error, unmapped address
    input  wire logic [31:0] nvm_defaults,                  // default bytes, pin6..pin3 high to low
    input  wire logic [3:0]  pin_in,                        // pad input levels, pin6..pin3
    output logic      [3:0]  pin_out,                       // pad output levels
    output logic      [3:0]  pin_oe,                        // pad output enables, high drives
    output logic      [3:0]  pin_pull_en,                   // pull resistor enables
    output logic      [3:0]  pin_pull_up,                   // pull-up when set, else pull-down
    input  wire logic        second_i2c_data_line_out,      // core i2c data drive level
    input  wire logic        spi_serial_data_output,        // core spi data out
    input  wire logic        sync_clock_output,             // core sync clock out
    input  wire logic        system_reset_output_low,       // core reset out, active low
    input  wire logic        power_good_output,             // core power good
    output logic             second_i2c_data_line_in,       // i2c data seen on pin3
    output logic             enable_input,                  // device enable from pin4
    output logic             watchdog_trigger_input,        // watchdog trigger from pin4
    output logic             first_regulator_monitor_on_pin4, // monitor samples pin4
    output logic             sync_clock_input,              // sync clock from pin5
    output logic             controller_error_input_low,    // error input from pin6, active low
    output logic             sleep_request_1,               // sleep request 1
    output logic             sleep_request_2,               // sleep request 2
    output logic             wake_request_1,                // wake request 1
    output logic             wake_request_2                 // wake request 2
);
    localparam logic [2:0] SLOT_NONE = 3'h7;
    // pulls stay enabled as pull-down through reset, matching the nominal byte
    localparam mpc_pkg::mpc_state_t RST = '{cfg: {4{`MPC_CFG_RESET}}, i2c_in: 1'b1, pull_en: 4'hF,
                                           err_n: 1'b1, default: '0};

    mpc_pkg::mpc_state_t st_reg;
    mpc_pkg::mpc_state_t st_next;
    logic [3:0]          level;
    logic [3:0]          filt_on;

    // map a byte address to a register slot; misaligned or unknown gives none
    function automatic logic [2:0] slot_of(input logic [11:0] a);
        logic [2:0] s;
        s = SLOT_NONE;
        if (a[1:0] == 2'h0) begin
            case (a[11:2])
                `MPC_IDX_PIN3:   s = 3'h0;
                `MPC_IDX_PIN4:   s = 3'h1;
                `MPC_IDX_PIN5:   s = 3'h2;
                `MPC_IDX_PIN6:   s = 3'h3;
                `MPC_IDX_GP_OUT: s = 3'h4;
                `MPC_IDX_GP_IN:  s = 3'h5;
                default:         s = SLOT_NONE;
            endcase
        end
        return s;
    endfunction : slot_of

    // output level a pin carries for its function code
    function automatic logic out_of(input logic [1:0] pin, input logic [2:0] fn, input logic gp);
        logic v;
        v = 1'b0;
        if (fn == 3'h0) begin
            v = gp;
        end else begin
            unique case (pin)
                2'h0: v = (fn == 3'h1) ? second_i2c_data_line_out
                        : ((fn == 3'h2) || (fn == 3'h3)) ? spi_serial_data_output : 1'b0;
                2'h1: v = 1'b0;  // all pin4 functions are inputs
                2'h2: v = (fn == 3'h2) ? sync_clock_output
                        : (fn == 3'h3) ? system_reset_output_low : 1'b0;
                2'h3: v = (fn == 3'h2) ? sync_clock_output
                        : (fn == 3'h3) ? power_good_output : 1'b0;
            endcase
        end
        return v;
    endfunction : out_of

    // one synchroniser and filter per pin; filtering only while the pin is an input
    for (genvar g = 0; g < 4; g++) begin : g_pin
        assign filt_on[g] = st_reg.cfg[g][4] & ~st_reg.cfg[g][0];
        mpc_deglitch #(
            .CNT_W (10),
            .COUNT (DG_COUNT)
        ) u_dg (
            .pclk      (pclk),
            .presetn   (presetn),
            .pin_async (pin_in[g]),
            .filter_on (filt_on[g]),
            .level     (level[g])
        );
    end

    // next state: defaults load, apb access, pin drive and core input routing
    always_comb begin
        logic [2:0] slot;
        logic [2:0] fn;
        logic       v;
        st_next = st_reg;
        slot    = slot_of(paddr);
        fn      = 3'h0;
        v       = 1'b0;
        // non-volatile defaults land on the first edge after reset release
        if (!st_reg.loaded) begin
            st_next.loaded = 1'b1;
            st_next.cfg    = nvm_defaults;
        end
        // one wait state: ready rises one cycle into the access phase
        if (psel && penable && st_reg.loaded) begin
            if (!st_reg.pready) begin
                st_next.pready  = 1'b1;
                st_next.pslverr = (slot == SLOT_NONE);
                unique case (slot)
                    3'h0, 3'h1, 3'h2, 3'h3: st_next.prdata = {24'h0, st_reg.cfg[slot[1:0]]};
                    3'h4:    st_next.prdata = {28'h0, st_reg.gp_out};
                    3'h5:    st_next.prdata = {28'h0, level};
                    default: st_next.prdata = 32'h0;
                endcase
            end else begin
                st_next.pready  = 1'b0;
                st_next.pslverr = 1'b0;
                if (pwrite) begin
                    unique case (slot)
                        3'h0, 3'h1, 3'h2, 3'h3: st_next.cfg[slot[1:0]] = pwdata[7:0];
                        3'h4:    st_next.gp_out = pwdata[3:0];
                        default: st_next.gp_out = st_reg.gp_out;  // read-only or unmapped
                    endcase
                end
            end
        end else begin
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
        end
        // pad controls are registered together so a write never glitches the pin
        for (int i = 0; i < 4; i++) begin
            fn = st_reg.cfg[i][`MPC_SEL_MSB:`MPC_SEL_LSB];
            v  = out_of(2'(i), fn, st_reg.gp_out[i]);
            st_next.pull_en[i] = st_reg.cfg[i][3];
            st_next.pull_up[i] = st_reg.cfg[i][3] & st_reg.cfg[i][2];
            if (st_reg.cfg[i][0]) begin
                st_next.pin_oe[i]  = st_reg.cfg[i][1] ? ~v : 1'b1;
                st_next.pin_out[i] = st_reg.cfg[i][1] ? 1'b0 : v;
            end else begin
                st_next.pin_oe[i]  = 1'b0;
                st_next.pin_out[i] = 1'b0;
            end
        end
        // core inputs; idle values are the inactive level of each signal
        st_next.i2c_in   = (st_reg.cfg[0][7:5] == 3'h1) ? level[0] : 1'b1;
        st_next.en_in    = (st_reg.cfg[1][7:5] == 3'h1) & level[1];
        st_next.wdog     = (st_reg.cfg[1][7:5] == 3'h2) & level[1];
        st_next.vmon_sel = (st_reg.cfg[1][7:5] == 3'h3);
        st_next.sync_in  = (st_reg.cfg[2][7:5] == 3'h1) & level[2];
        st_next.err_n    = (st_reg.cfg[3][7:5] == 3'h1) ? level[3] : 1'b1;
        // several pins may share a request; any one asserts it
        st_next.slp1 = 1'b0;
        st_next.slp2 = 1'b0;
        st_next.wk1  = 1'b0;
        st_next.wk2  = 1'b0;
        for (int i = 0; i < 4; i++) begin
            st_next.slp1 = st_next.slp1 | ((st_reg.cfg[i][7:5] == 3'h4) & level[i]);
            st_next.slp2 = st_next.slp2 | ((st_reg.cfg[i][7:5] == 3'h5) & level[i]);
            st_next.wk1  = st_next.wk1 | ((st_reg.cfg[i][7:5] == 3'h6) & level[i]);
            st_next.wk2  = st_next.wk2 | ((st_reg.cfg[i][7:5] == 3'h7) & level[i]);
        end
    end

    // state register; reset shows the nominal byte until defaults load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // every output is a flip-flop of the state record
    assign prdata                          = st_reg.prdata;
    assign pready                          = st_reg.pready;
    assign pslverr                         = st_reg.pslverr;
    assign pin_out                         = st_reg.pin_out;
    assign pin_oe                          = st_reg.pin_oe;
    assign pin_pull_en                     = st_reg.pull_en;
    assign pin_pull_up                     = st_reg.pull_up;
    assign second_i2c_data_line_in         = st_reg.i2c_in;
    assign enable_input                    = st_reg.en_in;
    assign watchdog_trigger_input          = st_reg.wdog;
    assign first_regulator_monitor_on_pin4 = st_reg.vmon_sel;
    assign sync_clock_input                = st_reg.sync_in;
    assign controller_error_input_low      = st_reg.err_n;
    assign sleep_request_1                 = st_reg.slp1;
    assign sleep_request_2                 = st_reg.slp2;
    assign wake_request_1                  = st_reg.wk1;
    assign wake_request_2                  = st_reg.wk2;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_reset_byte: assert property (!st_reg.loaded |-> (st_reg.cfg == {4{`MPC_CFG_RESET}}))
        else $error("pin registers not at nominal default before load");
    chk_nvm_load: assert property ($rose(st_reg.loaded) |-> (st_reg.cfg == $past(nvm_defaults)))
        else $error("non-volatile defaults not loaded");
    chk_write_pin3: assert property (psel && penable && pready && pwrite && (paddr == 12'h0CC)
        |=> ##1 (pin_pull_en[0] == $past(pwdata[3], 2)))
        else $error("pin3 write did not reach the pull enable in two cycles");
    chk_monitor_sel: assert property (##1 (first_regulator_monitor_on_pin4
        == ($past(st_reg.cfg[1][7:5]) == 3'h3)))
        else $error("monitor input selection wrong");
    chk_wdog_route: assert property ($past(st_reg.cfg[1][7:5]) == 3'h2
        |-> (watchdog_trigger_input == $past(level[1])))
        else $error("watchdog trigger not routed from pin4");
    chk_sleep_route: assert property (($past(st_reg.cfg[0][7:5]) == 3'h4) && $past(level[0])
        |-> sleep_request_1)
        else $error("sleep request 1 missed from pin3");
    chk_spi_pin3: assert property ($past(st_reg.cfg[0][0] && !st_reg.cfg[0][1]
        && (st_reg.cfg[0][7:6] == 2'h1)) |-> (pin_out[0] == $past(spi_serial_data_output)))
        else $error("spi data not driven on pin3");
    chk_reset_pin5: assert property ($past(st_reg.cfg[2] == 8'h61)
        |-> (pin_out[2] == $past(system_reset_output_low)) && pin_oe[2])
        else $error("reset output not driven on pin5");
    chk_power_good_output_pin6: assert property ($past(st_reg.cfg[3] == 8'h61)
        |-> (pin_out[3] == $past(power_good_output)))
        else $error("power good not driven on pin6");
    chk_open_drain: assert property ($past(st_reg.cfg[2][1]) |-> !pin_out[2])
        else $error("open-drain pin drives high");
    chk_input_dir: assert property (!$past(st_reg.cfg[3][0]) |-> !pin_oe[3])
        else $error("input pin is driven");
    chk_pull_dir: assert property (##1 (pin_pull_up[1] == $past(st_reg.cfg[1][3] & st_reg.cfg[1][2])))
        else $error("pull direction wrong on pin4");
    chk_apb_wait: assert property (psel && penable && !pready && st_reg.loaded |=> pready)
        else $error("apb ready late");

    cov_pin3_write: cover property (psel && penable && pready && pwrite && (paddr == 12'h0CC));
    cov_unmapped:   cover property (pready && pslverr);
    cov_sleep:      cover property (sleep_request_1);
    cov_filter:     cover property (filt_on[0] ##1 $changed(level[0]));

endmodule : mpc_pin_config

// ==== verif/mpc_pad_far.sv ====
/*
 * Far-side model of the four pads: external logic that may drive each pad, plus pad resolution.
 * Assumes the bench commands ext_level and ext_en, and the design's pad controls are registered.
 */
`timescale 1ns/1ns
module mpc_pad_far (
    input  wire logic       pclk,        // block clock
    input  wire logic [3:0] pin_out,     // device output level
    input  wire logic [3:0] pin_oe,      // device drives the pad
    input  wire logic [3:0] pin_pull_en, // device pull enabled
    input  wire logic [3:0] pin_pull_up, // pull-up when set
    input  wire logic [3:0] ext_level,   // level the far logic drives
    input  wire logic [3:0] ext_en,      // far logic drives the pad
    output logic      [3:0] pin_in       // resolved pad level
);
    // an undriven, unpulled pad wanders, so a stale level can never pass a check
    logic [3:0] float_lvl = 4'h5;
    always @(posedge pclk) begin
        float_lvl <= ~float_lvl;
    end

    // device driver wins, then the far driver, then the pull, else the wandering level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_level[i] :
                        pin_pull_en[i] ? pin_pull_up[i] : float_lvl[i];
        end
    end
endmodule : mpc_pad_far

// ==== verif/multipurpose_pin_config_tb.sv ====
/*
 * Self-checking bench for the pin configuration block: APB tasks, pad and core-signal checks.
 * Assumes the far-side pad model and a shortened deglitch count of 4 cycles.
 */
`timescale 1ns/1ns
module multipurpose_pin_config_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, nvm_defaults;
    logic [3:0]  pin_in, pin_out, pin_oe, pin_pull_en, pin_pull_up, ext_level, ext_en;
    logic [4:0]  core;     // {power good, reset out, sync out, spi out, i2c out}
    logic [9:0]  iv;       // levels handed to the core
    logic        i2c_i, en_i, wd_i, vm_i, sy_i, er_i, s1, s2, w1, w2;
    int          fails, checked;

    assign iv = {i2c_i, en_i, wd_i, vm_i, sy_i, er_i, s1, s2, w1, w2};

    mpc_pin_config #(.DG_COUNT(4)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nvm_defaults(nvm_defaults), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_en(pin_pull_en), .pin_pull_up(pin_pull_up), .second_i2c_data_line_out(core[0]),
        .spi_serial_data_output(core[1]), .sync_clock_output(core[2]), .system_reset_output_low(core[3]),
        .power_good_output(core[4]), .second_i2c_data_line_in(i2c_i), .enable_input(en_i),
        .watchdog_trigger_input(wd_i), .first_regulator_monitor_on_pin4(vm_i), .sync_clock_input(sy_i),
        .controller_error_input_low(er_i), .sleep_request_1(s1), .sleep_request_2(s2),
        .wake_request_1(w1), .wake_request_2(w2));

    mpc_pad_far far (
        .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
        .pin_pull_up(pin_pull_up), .ext_level(ext_level), .ext_en(ext_en), .pin_in(pin_in));

    task wrap_up;
        $display("checks made %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function logic [11:0] adr(input int p);
        return 12'h0CC + 12'(4 * p);
    endfunction : adr

    // one transfer; the request is held until pready is sampled high, then released
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wreg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wreg

    task rchk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, eexp});
    endtask : rchk

    // pad p must show the given enable and level two edges after a write
    task pad(input int p, input logic eo, input logic ev);
        repeat (2) @(posedge pclk);
        check({30'h0, pin_oe[p], pin_out[p]}, {30'h0, eo, ev});
    endtask : pad

    // selected core source is set opposite to all others, so a wrong pick shows
    task ofn(input int p, input logic [7:0] cfg, input int k);
        wreg(adr(p), {24'h0, cfg});
        for (int v = 0; v < 2; v++) begin
            core <= (v == 1) ? 5'(1 << k) : ~5'(1 << k);
            pad(p, 1'b1, v[0]);
        end
        wreg(adr(p), 32'h0A);
    endtask : ofn

    // far logic drives pad p high then low; core levels compared with both
    task ifn(input int p, input logic [7:0] cfg, input logic [9:0] e1, input logic [9:0] e0);
        wreg(adr(p), {24'h0, cfg});
        ext_en <= 4'(1 << p);
        ext_level <= 4'hF;
        repeat (8) @(posedge pclk);
        check({22'h0, iv}, {22'h0, e1});
        rchk(12'h104, 32'(1 << p), 1'b0);
        ext_level <= 4'h0;
        repeat (8) @(posedge pclk);
        check({22'h0, iv}, {22'h0, e0});
        ext_en <= 4'h0;
        wreg(adr(p), 32'h0A);
    endtask : ifn

    // pulse pad of pin3 for n cycles and note whether sleep request 1 is high in the 12 cycles after the pulse
    task pulse(input int n, output logic seen);
        seen = 1'b0;
        ext_level[0] <= 1'b1;
        repeat (n) @(posedge pclk);
        ext_level[0] <= 1'b0;
        repeat (12) begin
            @(posedge pclk);
            seen = seen | s1;
        end
    endtask : pulse

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // watchdog sized well above the roughly 1000 cycles the sequence needs
    initial begin
        #(8 * 20000);
        fails++;
        wrap_up();
    end

    initial begin : main
        logic sn;
        {presetn, psel, penable, pwrite, paddr, pwdata, core, ext_en, ext_level} = '0;
        fails = 0;
        checked = 0;
        nvm_defaults = 32'h0A0A0A0A;
        repeat (8) @(posedge pclk);
        check({28'h0, pin_pull_en}, 32'hF);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        for (int p = 0; p < 4; p++) rchk(adr(p), 32'h0A, 1'b0);
        check({20'h0, pin_pull_en, pin_pull_up, pin_oe}, 32'hF00);
        for (int p = 0; p < 4; p++) begin
            wreg(adr(p), 32'hFFFFFF55);
            rchk(adr(p), 32'h55, 1'b0);
            wreg(adr(p), 32'hAA);
            rchk(adr(p), 32'hAA, 1'b0);
            wreg(adr(p), 32'h0A);
        end
        wreg(adr(0), 32'h0C);
        repeat (2) @(posedge pclk);
        check({30'h0, pin_pull_en[0], pin_pull_up[0]}, 32'h3);
        wreg(adr(0), 32'h04);
        repeat (2) @(posedge pclk);
        check({30'h0, pin_pull_en[0], pin_pull_up[0]}, 32'h0);
        wreg(adr(0), 32'h01);
        wreg(12'h100, 32'h1);
        pad(0, 1'b1, 1'b1);
        wreg(12'h100, 32'h0);
        pad(0, 1'b1, 1'b0);
        wreg(adr(0), 32'h03);
        wreg(12'h100, 32'h1);
        pad(0, 1'b0, 1'b0);
        wreg(12'h100, 32'h0);
        pad(0, 1'b1, 1'b0);
        wreg(adr(0), 32'h02);
        pad(0, 1'b0, 1'b0);
        ofn(0, 8'h21, 0);
        ofn(0, 8'h41, 1);
        ofn(0, 8'h61, 1);
        ofn(2, 8'h41, 2);
        ofn(2, 8'h61, 3);
        ofn(3, 8'h41, 2);
        ofn(3, 8'h61, 4);
        ifn(0, 8'h20, 10'h210, 10'h010);
        ifn(1, 8'h20, 10'h310, 10'h210);
        ifn(1, 8'h40, 10'h290, 10'h210);
        ifn(1, 8'h60, 10'h250, 10'h250);
        ifn(2, 8'h20, 10'h230, 10'h210);
        ifn(3, 8'h20, 10'h210, 10'h200);
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < 4; c++) ifn(p, 8'((4 + c) << 5), 10'h210 | 10'(8 >> c), 10'h210);
        end
        ext_en <= 4'h1;
        wreg(adr(0), 32'h90);
        pulse(2, sn);
        check({31'h0, sn}, 32'h0);
        pulse(20, sn);
        check({31'h0, sn}, 32'h1);
        wreg(adr(0), 32'h80);
        pulse(2, sn);
        check({31'h0, sn}, 32'h1);
        ext_en <= 4'h0;
        wreg(12'h0E0, 32'hFF);
        rchk(12'h0E0, 32'h0, 1'b1);
        rchk(adr(1), 32'h0A, 1'b0);
        nvm_defaults <= 32'h815A3C1F;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        for (int p = 0; p < 4; p++) rchk(adr(p), {24'h0, nvm_defaults[8*p +: 8]}, 1'b0);
        wrap_up();
    end
endmodule : multipurpose_pin_config_tb
